// ---- logic/exc_entry_pkg.sv ----
// Package with constants and types for the exception entry block.
`default_nettype none
package exc_entry_pkg;
  // -------------------------------------------------------------------
  // Vector addresses
  // -------------------------------------------------------------------
  localparam logic [31:0] VEC_RESET = 32'hbfc0_0000;
  localparam logic [31:0] VEC_REFILL0 = 32'h8000_0000;
  localparam logic [31:0] VEC_REFILL1 = 32'hbfc0_0200;
  localparam logic [31:0] VEC_CACHE0 = 32'ha000_0100;
  localparam logic [31:0] VEC_CACHE1 = 32'hbfc0_0300;
  localparam logic [31:0] VEC_IRQ0 = 32'h8000_0200;
  localparam logic [31:0] VEC_IRQ1 = 32'hbfc0_0400;
  localparam logic [31:0] VEC_GEN0 = 32'h8000_0180;
  localparam logic [31:0] VEC_GEN1 = 32'hbfc0_0380;
  localparam logic [31:0] VEC_DBG_PROBE = 32'hff20_0200;
  localparam logic [31:0] VEC_DBG_ROM = 32'hbfc0_0480;
  localparam logic [31:0] SLOT_BYTES = 32'h0000_0004;
  // -------------------------------------------------------------------
  // Exception codes
  // -------------------------------------------------------------------
  localparam logic [4:0] CODE_INT = 5'h00;
  localparam logic [4:0] CODE_MOD = 5'h01;
  localparam logic [4:0] CODE_TLBL = 5'h02;
  localparam logic [4:0] CODE_TLBS = 5'h03;
  localparam logic [4:0] CODE_ADEL = 5'h04;
  localparam logic [4:0] CODE_ADES = 5'h05;
  localparam logic [4:0] CODE_CACHE = 5'h1e;
  // -------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CAUSE = 8'h04;
  localparam logic [7:0] OFS_EPC = 8'h08;
  localparam logic [7:0] OFS_ERRPC = 8'h0c;
  localparam logic [7:0] OFS_BADVA = 8'h10;
  localparam logic [7:0] OFS_CONTEXT = 8'h14;
  // -------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------
  localparam int ST_EXL = 16;
  localparam int ST_ERL = 17;
  localparam int ST_BEV = 22;
  localparam int ST_PROBE = 23;
  localparam int CA_IV = 23;
  localparam int CA_BD = 31;
  localparam logic [31:0] STATUS_RST = 32'h0042_0000;
  localparam logic [3:0] KILL_ALL = 4'hf;
  localparam logic [3:0] KILL_YOUNG = 4'h7;
  typedef enum logic [2:0] {K_NONE, K_RESET, K_STAGE, K_DEBUG, K_IRQ, K_ERET} entry_kind_type;
endpackage
`default_nettype wire

// ---- logic/exception_vector_entry.sv ----
// Exception entry: vector choice, return PC, status stack, cause and registers.
// Overview of operation
// [RULE1] Handler fetch issued one clock after detection.
// [RULE2] Interrupt: MEM completes, ALU instruction is return.
// [RULE3] Interrupt inputs pass a two-flop synchroniser.
// [RULE4] Reset, soft reset, NMI use reset vector.
// [RULE5] Refill vector depends on boot select, level.
// [RULE6] Cache errors use dedicated uncached vector.
// [RULE7] Dedicated interrupt vector when its bit set.
// [RULE8] Dedicated vector bit is writable in cause.
// [RULE9] All other exceptions use general vector.
// [RULE10] Boot select picks ROM or cached vectors.
// [RULE11] Error-class saves error PC, others normal.
// [RULE12] Push mode/enable stack, enter kernel disabled.
// [RULE13] Cause holds code and pending interrupts.
// [RULE14] Addressing faults load the faulting address.
// [RULE15] Memory faults update translation context register.
// [RULE16] Redirect only after state is updated.
// [RULE17] Float unit writes only non-faulting results.
// [RULE18] Multiply/divide results are not rolled back.
// [RULE19] Delay slot fault returns to branch, flags.
// [RULE20] Return resumes at active level's PC.
// [RULE21] Debug vector chosen by probe-present bit.
// [RULE22] Oldest instruction's exception wins, younger suppressed.
`default_nettype none
module exception_vector_entry #(
  parameter int IRQ_W = 8
) (
  input wire logic i_clk, // Core clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [3:0] i_stage_exc, // Exception per stage, 3 is MEM, 0 fetch.
  input wire logic [3:0][4:0] i_stage_code, // Exception code per stage.
  input wire logic [3:0] i_stage_refill, // Fault is a TLB refill miss.
  input wire logic [3:0] i_stage_bd, // Instruction sits in a delay slot.
  input wire logic [3:0][31:0] i_stage_pc, // PC per stage.
  input wire logic [3:0][31:0] i_stage_badva, // Faulting address per stage.
  input wire logic [IRQ_W-1:0] i_irq, // Asynchronous interrupt lines.
  input wire logic i_nmi, // Non-maskable interrupt.
  input wire logic i_soft_reset, // Soft reset request.
  input wire logic i_debug_req, // Debug exception request.
  input wire logic i_eret, // Return-from-exception executes.
  input wire logic i_fpu_done, // Float unit result ready.
  input wire logic i_fpu_exc, // Float unit result raises.
  input wire logic [7:0] i_addr, // Register byte address.
  input wire logic [31:0] i_wdata, // Register write data.
  input wire logic i_we, // Register write strobe.
  input wire logic i_re, // Register read strobe.
  output logic [31:0] o_rdata, // Read data, cycle after strobe.
  output logic o_redirect, // One-cycle fetch redirect.
  output logic [31:0] o_vector, // Redirect target address.
  output logic [3:0] o_kill, // Stages nullified with redirect.
  output logic o_fpu_wr_en // Float register file write enable.
);
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  logic [31:0] status_word;
  logic [IRQ_W-1:0] irq_s1, irq_s2;
  logic [4:0] cause_code;
  logic delay_slot_flag, dedicated_irq_vector;
  logic [31:0] exception_return_pc, error_return_pc, faulting_address, mmu_context;
  logic boot_pending;
  exc_entry_pkg::entry_kind_type next_kind;
  logic next_err, next_bd, irq_take, found;
  logic [1:0] sel;
  logic [4:0] next_code;
  logic [31:0] next_pc, next_vec;
  logic [3:0] next_kill;
  logic take;

  function automatic logic [31:0] vector_select(input logic [4:0] code, input logic refill,
                                                input logic boot_vector_select, input logic exception_level,
                                                input logic iv);
    if (refill && !exception_level) begin
      return boot_vector_select ? exc_entry_pkg::VEC_REFILL1 : exc_entry_pkg::VEC_REFILL0; // [RULE5]
    end
    if (code == exc_entry_pkg::CODE_CACHE) begin
      return boot_vector_select ? exc_entry_pkg::VEC_CACHE1 : exc_entry_pkg::VEC_CACHE0; // [RULE6]
    end
    if (code == exc_entry_pkg::CODE_INT && iv) begin
      return boot_vector_select ? exc_entry_pkg::VEC_IRQ1 : exc_entry_pkg::VEC_IRQ0; // [RULE7]
    end
    return boot_vector_select ? exc_entry_pkg::VEC_GEN1 : exc_entry_pkg::VEC_GEN0; // [RULE9] [RULE10]
  endfunction

  function automatic logic [3:0] kill_mask(input logic [1:0] s);
    return 4'((5'h02 << s) - 5'h01);
  endfunction

  // -------------------------------------------------------------------
  // Interrupt synchroniser
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_s1 <= '0;
      irq_s2 <= '0;
    end else begin
      irq_s1 <= i_irq; // [RULE3]
      irq_s2 <= irq_s1;
    end
  end

  assign irq_take = |(irq_s2 & status_word[8 +: IRQ_W]) && status_word[0]
                    && !status_word[exc_entry_pkg::ST_EXL] && !status_word[exc_entry_pkg::ST_ERL];

  // -------------------------------------------------------------------
  // Entry decision
  // -------------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    sel = 2'd0;
    next_kind = exc_entry_pkg::K_NONE;
    next_err = 1'b0;
    next_bd = 1'b0;
    next_code = exc_entry_pkg::CODE_INT;
    next_pc = i_stage_pc[2];
    next_vec = exc_entry_pkg::VEC_GEN0;
    next_kill = 4'h0;
    // Later loop passes are older stages, so the oldest fault wins.
    for (int s = 0; s < 4; s++) begin
      if (i_stage_exc[s]) begin
        found = 1'b1; // [RULE22]
        sel = 2'(s);
      end
    end
    if (boot_pending || i_soft_reset || i_nmi) begin
      next_kind = exc_entry_pkg::K_RESET;
      next_err = 1'b1;
      next_pc = i_stage_pc[3];
      next_vec = exc_entry_pkg::VEC_RESET; // [RULE4]
      next_kill = exc_entry_pkg::KILL_ALL;
    end else if (found) begin
      next_kind = exc_entry_pkg::K_STAGE;
      next_code = i_stage_code[sel];
      next_bd = i_stage_bd[sel];
      next_pc = i_stage_bd[sel] ? i_stage_pc[sel] - exc_entry_pkg::SLOT_BYTES
                                : i_stage_pc[sel]; // [RULE19]
      next_err = (i_stage_code[sel] == exc_entry_pkg::CODE_CACHE); // [RULE11]
      next_vec = vector_select(i_stage_code[sel], i_stage_refill[sel],
                               status_word[exc_entry_pkg::ST_BEV],
                               status_word[exc_entry_pkg::ST_EXL], dedicated_irq_vector);
      next_kill = kill_mask(sel); // [RULE22]
    end else if (i_debug_req) begin
      next_kind = exc_entry_pkg::K_DEBUG;
      next_vec = status_word[exc_entry_pkg::ST_PROBE] ? exc_entry_pkg::VEC_DBG_PROBE
                                                      : exc_entry_pkg::VEC_DBG_ROM; // [RULE21]
      next_kill = exc_entry_pkg::KILL_YOUNG;
    end else if (irq_take) begin
      // The MEM instruction completes; the ALU instruction is the return point.
      next_kind = exc_entry_pkg::K_IRQ; // [RULE2]
      next_bd = i_stage_bd[2];
      next_pc = i_stage_bd[2] ? i_stage_pc[2] - exc_entry_pkg::SLOT_BYTES
                              : i_stage_pc[2]; // [RULE19]
      next_vec = vector_select(exc_entry_pkg::CODE_INT, 1'b0,
                               status_word[exc_entry_pkg::ST_BEV],
                               status_word[exc_entry_pkg::ST_EXL], dedicated_irq_vector);
      next_kill = exc_entry_pkg::KILL_YOUNG; // [RULE2]
    end else if (i_eret) begin
      next_kind = exc_entry_pkg::K_ERET;
      next_vec = status_word[exc_entry_pkg::ST_ERL] ? error_return_pc
                                                    : exception_return_pc; // [RULE20]
      next_kill = exc_entry_pkg::KILL_YOUNG;
    end
  end

  assign take = (next_kind != exc_entry_pkg::K_NONE) && (next_kind != exc_entry_pkg::K_ERET);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_pending <= 1'b1;
    end else begin
      boot_pending <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Redirect; state below updates on this same edge, before the fetch.
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_redirect <= 1'b0;
      o_vector <= exc_entry_pkg::VEC_RESET;
      o_kill <= 4'h0;
    end else begin
      o_redirect <= (next_kind != exc_entry_pkg::K_NONE); // [RULE1] [RULE16]
      o_vector <= next_vec;
      o_kill <= next_kill; // [RULE18]
    end
  end

  // -------------------------------------------------------------------
  // Return PCs
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exception_return_pc <= 32'h0000_0000;
    end else if (take && !next_err) begin
      exception_return_pc <= next_pc; // [RULE11]
    end else if (i_we && i_addr == exc_entry_pkg::OFS_EPC) begin
      exception_return_pc <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      error_return_pc <= 32'h0000_0000;
    end else if (take && next_err) begin
      error_return_pc <= next_pc; // [RULE11]
    end else if (i_we && i_addr == exc_entry_pkg::OFS_ERRPC) begin
      error_return_pc <= i_wdata;
    end
  end

  // -------------------------------------------------------------------
  // Status word
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_word <= exc_entry_pkg::STATUS_RST;
    end else if (take) begin
      status_word[5:0] <= {status_word[3:0], 2'b00}; // [RULE12]
      if (next_err) begin
        status_word[exc_entry_pkg::ST_ERL] <= 1'b1;
        status_word[exc_entry_pkg::ST_BEV] <= 1'b1;
      end else begin
        status_word[exc_entry_pkg::ST_EXL] <= 1'b1;
      end
    end else if (next_kind == exc_entry_pkg::K_ERET) begin
      status_word[5:0] <= {status_word[5:4], status_word[5:2]};
      if (status_word[exc_entry_pkg::ST_ERL]) begin
        status_word[exc_entry_pkg::ST_ERL] <= 1'b0; // [RULE20]
      end else begin
        status_word[exc_entry_pkg::ST_EXL] <= 1'b0; // [RULE20]
      end
    end else if (i_we && i_addr == exc_entry_pkg::OFS_STATUS) begin
      status_word <= i_wdata;
    end
  end

  // -------------------------------------------------------------------
  // Cause state
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cause_code <= exc_entry_pkg::CODE_INT;
      delay_slot_flag <= 1'b0;
    end else if (take) begin
      cause_code <= next_code; // [RULE13]
      delay_slot_flag <= next_bd; // [RULE19]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dedicated_irq_vector <= 1'b0;
    end else if (i_we && i_addr == exc_entry_pkg::OFS_CAUSE) begin
      dedicated_irq_vector <= i_wdata[exc_entry_pkg::CA_IV]; // [RULE8]
    end
  end

  // -------------------------------------------------------------------
  // Fault address and translation context
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      faulting_address <= 32'h0000_0000;
      mmu_context <= 32'h0000_0000;
    end else if (next_kind == exc_entry_pkg::K_STAGE) begin
      if (next_code >= exc_entry_pkg::CODE_MOD && next_code <= exc_entry_pkg::CODE_ADES) begin
        faulting_address <= i_stage_badva[sel]; // [RULE14]
      end
      if (next_code >= exc_entry_pkg::CODE_MOD && next_code <= exc_entry_pkg::CODE_TLBS) begin
        mmu_context <= {i_stage_badva[sel][31:13], 13'h0000}; // [RULE15]
      end
    end
  end

  // -------------------------------------------------------------------
  // Float unit write gate
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fpu_wr_en <= 1'b0;
    end else begin
      o_fpu_wr_en <= i_fpu_done && !i_fpu_exc && !take; // [RULE17]
    end
  end

  // -------------------------------------------------------------------
  // Register read
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_re) begin
      case (i_addr)
        exc_entry_pkg::OFS_STATUS: o_rdata <= status_word;
        exc_entry_pkg::OFS_CAUSE: begin
          o_rdata <= 32'h0000_0000;
          o_rdata[6:2] <= cause_code;
          o_rdata[8 +: IRQ_W] <= irq_s2; // [RULE13]
          o_rdata[exc_entry_pkg::CA_IV] <= dedicated_irq_vector;
          o_rdata[exc_entry_pkg::CA_BD] <= delay_slot_flag;
        end
        exc_entry_pkg::OFS_EPC: o_rdata <= exception_return_pc;
        exc_entry_pkg::OFS_ERRPC: o_rdata <= error_return_pc;
        exc_entry_pkg::OFS_BADVA: o_rdata <= faulting_address;
        exc_entry_pkg::OFS_CONTEXT: o_rdata <= mmu_context;
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_entry_latency: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
    take |=> o_redirect) else $error("entry redirect missing");
  a_irq_return_pc: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE2]
    (next_kind == exc_entry_pkg::K_IRQ && !i_stage_bd[2]) |=>
    (exception_return_pc == $past(i_stage_pc[2]) && o_kill == exc_entry_pkg::KILL_YOUNG))
    else $error("interrupt return pc wrong");
  a_irq_two_flop: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE3]
    ##2 irq_s2 == $past(i_irq, 2)) else $error("interrupt sync depth wrong");
  a_reset_vector: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE4]
    (next_kind == exc_entry_pkg::K_RESET) |=> o_vector == exc_entry_pkg::VEC_RESET)
    else $error("reset vector wrong");
  a_error_pc_save: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE11]
    (take && next_err) |=> (error_return_pc == $past(next_pc)
    && status_word[exc_entry_pkg::ST_ERL])) else $error("error pc not saved");
  a_status_push: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE12]
    take |=> (status_word[1:0] == 2'b00 && status_word[5:2] == $past(status_word[3:0])))
    else $error("status stack not pushed");
  a_delay_slot: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE19]
    (next_kind == exc_entry_pkg::K_STAGE && next_bd) |=> delay_slot_flag)
    else $error("delay slot flag not set");
  a_fpu_gate: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE17]
    o_fpu_wr_en |-> ($past(i_fpu_done) && !$past(i_fpu_exc))) else $error("fpu write leaked");
  a_eret_level: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE20]
    (next_kind == exc_entry_pkg::K_ERET && status_word[exc_entry_pkg::ST_ERL]) |=>
    (!status_word[exc_entry_pkg::ST_ERL] && o_vector == $past(error_return_pc)))
    else $error("return level not cleared");
endmodule
`default_nettype wire

// ---- tb/pipe_model.sv ----
// Pipeline model that raises per-stage exceptions for one cycle.
`default_nettype none
module pipe_model (
  input wire logic i_clk, // Core clock.
  output logic [3:0] o_exc, // Exception per stage.
  output logic [3:0][4:0] o_code, // Code per stage.
  output logic [3:0] o_refill, // Refill miss per stage.
  output logic [3:0] o_bd, // Delay slot per stage.
  output logic [3:0][31:0] o_pc, // PC per stage.
  output logic [3:0][31:0] o_badva // Faulting address per stage.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h0040_1000;
  initial begin
    o_exc = 4'h0;
    o_code = '0;
    o_refill = 4'h0;
    o_bd = 4'h0;
  end
  // Older stages hold lower addresses, as in program order.
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      o_pc[s] = BASE + 32'(4 * (3 - s));
      o_badva[s] = 32'h1234_6000 + 32'(s);
    end
  end
  task automatic raise(input logic [3:0] m, input logic [4:0] c, input logic rf, input logic b);
    @(posedge i_clk);
    o_exc <= m;
    o_code <= {4{c}};
    o_refill <= rf ? m : 4'h0;
    o_bd <= b ? m : 4'h0;
    @(posedge i_clk);
    o_exc <= 4'h0;
    o_refill <= 4'h0;
    o_bd <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_exception_vector_entry.sv ----
// Self-checking bench for the exception entry block.
`default_nettype none
module test_exception_vector_entry;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_irq = 8'h00;
  logic i_nmi = 1'b0, i_soft_reset = 1'b0, i_debug_req = 1'b0, i_eret = 1'b0;
  logic i_fpu_done = 1'b0, i_fpu_exc = 1'b0, i_we = 1'b0, i_re = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_vector;
  logic o_redirect, o_fpu_wr_en;
  logic [3:0] o_kill, s_exc, s_refill, s_bd;
  logic [3:0][4:0] s_code;
  logic [3:0][31:0] s_pc, s_badva;
  int fail_count = 0;
  int checked = 0;
  localparam logic [31:0] PC3 = 32'h0040_1000;
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  pipe_model i_pipe_model (.i_clk(i_clk), .o_exc(s_exc), .o_code(s_code), .o_refill(s_refill),
    .o_bd(s_bd), .o_pc(s_pc), .o_badva(s_badva));
  exception_vector_entry #(.IRQ_W(8)) i_exception_vector_entry (.i_clk(i_clk), .i_rst(i_rst),
    .i_stage_exc(s_exc), .i_stage_code(s_code), .i_stage_refill(s_refill), .i_stage_bd(s_bd),
    .i_stage_pc(s_pc), .i_stage_badva(s_badva), .i_irq(i_irq), .i_nmi(i_nmi),
    .i_soft_reset(i_soft_reset), .i_debug_req(i_debug_req), .i_eret(i_eret),
    .i_fpu_done(i_fpu_done), .i_fpu_exc(i_fpu_exc), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_redirect(o_redirect), .o_vector(o_vector),
    .o_kill(o_kill), .o_fpu_wr_en(o_fpu_wr_en));
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 chk(nm, e, o_rdata);
  endtask
  // Waits a bounded time for the redirect pulse, then judges target and kill mask.
  task automatic entry(input string nm, input logic [31:0] v, input logic [3:0] k, input bit ck);
    #1;
    for (int n = 0; n < 6 && o_redirect !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (o_redirect !== 1'b1) begin
      fail_count++;
      $display("mismatch %s redirect expected 1 seen %b", nm, o_redirect);
      print_verdict();
    end
    chk({nm, " vector"}, v, o_vector);
    if (ck) chk({nm, " kill"}, {28'h0, k}, {28'h0, o_kill});
  endtask
  task automatic pulse(input int w);
    @(posedge i_clk);
    case (w)
      0: i_nmi <= 1'b1;
      1: i_soft_reset <= 1'b1;
      2: i_debug_req <= 1'b1;
      default: i_eret <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_nmi, i_soft_reset, i_debug_req, i_eret} <= 4'h0;
  endtask
  task automatic stage(input string nm, input logic [3:0] m, input logic [4:0] c,
      input logic rf, input logic b, input logic [31:0] v);
    i_pipe_model.raise(m, c, rf, b);
    entry(nm, v, exc_entry_pkg::KILL_ALL, 1'b1);
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_general();
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0001);
    stage("older wins", 4'b1001, exc_entry_pkg::CODE_ADEL, 0, 0, exc_entry_pkg::VEC_GEN0);
    rd("epc", exc_entry_pkg::OFS_EPC, PC3);
    rd("badva", exc_entry_pkg::OFS_BADVA, 32'h1234_6003);
    rd("status push", exc_entry_pkg::OFS_STATUS, 32'h0001_0004);
    rd("cause code", exc_entry_pkg::OFS_CAUSE, 32'h0000_0010);
    stage("refill exl", 4'b1000, exc_entry_pkg::CODE_TLBL, 1, 0, exc_entry_pkg::VEC_GEN0);
    rd("context", exc_entry_pkg::OFS_CONTEXT, 32'h1234_6000);
    pulse(3);
    entry("eret", PC3, exc_entry_pkg::KILL_YOUNG, 1'b1);
    rd("status pop", exc_entry_pkg::OFS_STATUS, 32'h0000_0014);
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    stage("refill", 4'b1000, exc_entry_pkg::CODE_TLBS, 1, 0, exc_entry_pkg::VEC_REFILL0);
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    stage("slot", 4'b1000, exc_entry_pkg::CODE_ADES, 0, 1, exc_entry_pkg::VEC_GEN0);
    rd("slot epc", exc_entry_pkg::OFS_EPC, PC3 - 32'h4);
    rd("slot cause", exc_entry_pkg::OFS_CAUSE, 32'h8000_0014);
    $display("general entries done");
  endtask
  task automatic t_boot_select();
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    stage("cache", 4'b1000, exc_entry_pkg::CODE_CACHE, 0, 0, exc_entry_pkg::VEC_CACHE0);
    rd("error_return_pc", exc_entry_pkg::OFS_ERRPC, PC3);
    pulse(3);
    entry("eret error", PC3, exc_entry_pkg::KILL_YOUNG, 1'b1);
    stage("gen boot", 4'b1000, exc_entry_pkg::CODE_ADEL, 0, 0, exc_entry_pkg::VEC_GEN1);
    wr(exc_entry_pkg::OFS_STATUS, 32'h0040_0000);
    stage("refill boot", 4'b1000, exc_entry_pkg::CODE_TLBL, 1, 0, exc_entry_pkg::VEC_REFILL1);
    wr(exc_entry_pkg::OFS_STATUS, 32'h0040_0000);
    stage("cache boot", 4'b1000, exc_entry_pkg::CODE_CACHE, 0, 0, exc_entry_pkg::VEC_CACHE1);
    $display("boot select entries done");
  endtask
  // The line rises after one edge; recognition and decision take the next edges.
  task automatic irq_go(input string nm, input logic [31:0] v);
    int n;
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0101);
    @(posedge i_clk);
    i_irq <= 8'h01;
    for (n = 1; n <= 6; n++) begin
      @(posedge i_clk);
      #1;
      if (o_redirect === 1'b1) break;
    end
    chk({nm, " delay"}, 32'd3, 32'(n));
    chk({nm, " vector"}, v, o_vector);
    chk({nm, " kill"}, 32'h7, {28'h0, o_kill});
    rd({nm, " epc"}, exc_entry_pkg::OFS_EPC, PC3 + 32'h4);
    @(posedge i_clk);
    i_irq <= 8'h00;
  endtask
  task automatic t_irq();
    wr(exc_entry_pkg::OFS_CAUSE, 32'h0080_0000);
    irq_go("irq dedicated", exc_entry_pkg::VEC_IRQ0);
    rd("irq cause", exc_entry_pkg::OFS_CAUSE, 32'h0080_0100);
    wr(exc_entry_pkg::OFS_CAUSE, 32'h0000_0000);
    irq_go("irq general", exc_entry_pkg::VEC_GEN0);
    $display("interrupt entries done");
  endtask
  task automatic t_special();
    wr(exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    pulse(2);
    entry("debug rom", exc_entry_pkg::VEC_DBG_ROM, exc_entry_pkg::KILL_YOUNG, 1'b1);
    wr(exc_entry_pkg::OFS_STATUS, 32'h0080_0000);
    pulse(2);
    entry("debug probe", exc_entry_pkg::VEC_DBG_PROBE, exc_entry_pkg::KILL_YOUNG, 1'b1);
    for (int w = 0; w < 2; w++) begin
      wr(exc_entry_pkg::OFS_STATUS, 32'h0081_0000);
      pulse(w);
      entry("nmi or soft", exc_entry_pkg::VEC_RESET, exc_entry_pkg::KILL_ALL, 1'b1);
    end
    @(posedge i_clk);
    i_fpu_done <= 1'b1;
    @(posedge i_clk);
    i_fpu_done <= 1'b0;
    #1 chk("fpu write", 32'h1, {31'h0, o_fpu_wr_en});
    @(posedge i_clk);
    i_fpu_done <= 1'b1;
    i_fpu_exc <= 1'b1;
    @(posedge i_clk);
    i_fpu_done <= 1'b0;
    i_fpu_exc <= 1'b0;
    #1 chk("fpu blocked", 32'h0, {31'h0, o_fpu_wr_en});
    $display("special entries done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    entry("boot", exc_entry_pkg::VEC_RESET, exc_entry_pkg::KILL_ALL, 1'b1);
    rd("status reset", exc_entry_pkg::OFS_STATUS, exc_entry_pkg::STATUS_RST);
    rd("unmapped", 8'h40, 32'h0);
    t_general();
    t_boot_select();
    t_irq();
    t_special();
    print_verdict();
  end
endmodule
`default_nettype wire
